/* cip_port.sv */
// Six-pin configurable port with an Avalon-MM register slave.
// Assumes pad inputs are synchronous to sys_clk.
// What this block does
// - Each pin's direction set per pin.
// - Reset leaves every pin an input.
// - Writes to an input never reach pad.
// - Reads return pad level at read.
// - Output writes set pad; reads return value.
// - Alternate function overrides software pin control.
// - Outputs drive push-pull high and low.
// - Sixth pin can drive receiver enable.
// - Each pin has configurable pull up/down.
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

module cip_port #(
    parameter int unsigned N = cip_pkg::PIN_COUNT
) (
    // Clock, reset and clock enable.
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Avalon-MM slave.
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Internal function logic per pin.
    input  wire logic [N-1:0] alt_dir,
    input  wire logic [N-1:0] alt_out,
    // Pads.
    input  wire logic [N-1:0] pad_i,
    output logic [N-1:0]      pad_o,
    output logic [N-1:0]      pad_oe,
    output logic [N-1:0]      pad_pull_en,
    output logic [N-1:0]      pad_pull_up,
    // Receiver enable line, taken from the sixth pin's drive.
    output logic             position_receiver_enable
);

    ////////////////////////////////////////////////////////////////////
    // Register state.

    logic [N-1:0] dir_reg;       // Direction, 1 is output.
    logic [N-1:0] out_reg;       // Software output value.
    logic [N-1:0] alt_reg;       // Alternate function select.
    logic [N-1:0] pen_reg;       // Pull enable.
    logic [N-1:0] pup_reg;       // Pull polarity, 1 is up.
    logic         ack_reg;       // Answer phase of an access.
    logic [31:0]  rd_reg;        // Registered read data.

    // Word select decode used by reads and writes.
    function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
        hit = (a == o);
    endfunction : hit

    // A request is answered on the cycle after it is seen.
    logic req;     // A request that the running clock can take.
    logic wr_now;  // The edge at which a write commits.
    assign req    = (avs_read | avs_write) & clk_en;
    assign wr_now = avs_write & ack_reg & clk_en;
    // The answer is only given while the clock enable runs: a master
    // that left on a frozen cycle would see a write that never lands.
    assign avs_waitrequest = (avs_read | avs_write) & ~(ack_reg & clk_en);

    ////////////////////////////////////////////////////////////////////
    // Handshake: ack rises one cycle after the request, then drops.

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else if (clk_en) begin
            ack_reg <= req & ~ack_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Direction register; resets to all inputs.

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_reg <= cip_pkg::DIR_RST[N-1:0];
        end else if (wr_now && hit(avs_address, {1'b0, cip_pkg::OFS_DIR})
                     && avs_byteenable[0]) begin
            dir_reg <= avs_writedata[N-1:0];
        end
    end

    // Output value; only bits of output pins take the write, and the
    // value is kept through later direction changes.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= cip_pkg::OUT_RST[N-1:0];
        end else if (wr_now && hit(avs_address, {1'b0, cip_pkg::OFS_OUT})
                     && avs_byteenable[0]) begin
            // Input pins ignore the write.
            out_reg <= (avs_writedata[N-1:0] & dir_reg)
                       | (out_reg & ~dir_reg);
        end
    end

    // Alternate function select.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alt_reg <= cip_pkg::ALT_RST[N-1:0];
        end else if (wr_now && hit(avs_address, {1'b0, cip_pkg::OFS_ALT})
                     && avs_byteenable[0]) begin
            alt_reg <= avs_writedata[N-1:0];
        end
    end

    // Pull configuration: enables in byte 0, polarity in byte 1.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pen_reg <= cip_pkg::PULL_EN_RST[N-1:0];
            pup_reg <= cip_pkg::PULL_SEL_RST[N-1:0];
        end else if (wr_now && hit(avs_address, cip_pkg::OFS_PULL)) begin
            if (avs_byteenable[0]) begin
                pen_reg <= avs_writedata[N-1:0];
            end
            if (avs_byteenable[1]) begin
                pup_reg <= avs_writedata[cip_pkg::PULL_SEL_POS +: N];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data: pad level captured at the cycle the read is taken.

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_reg <= cip_pkg::UNMAPPED_RD;
        end else if (req && !ack_reg && avs_read) begin
            rd_reg <= cip_pkg::UNMAPPED_RD;
            if (hit(avs_address, {1'b0, cip_pkg::OFS_DIR})) begin
                rd_reg[N-1:0] <= dir_reg;
            end else if (hit(avs_address, {1'b0, cip_pkg::OFS_OUT})) begin
                rd_reg[N-1:0] <= out_reg;
            end else if (hit(avs_address, {1'b0, cip_pkg::OFS_IN})) begin
                rd_reg[N-1:0] <= pad_i;
            end else if (hit(avs_address, {1'b0, cip_pkg::OFS_ALT})) begin
                rd_reg[N-1:0] <= alt_reg;
            end else if (hit(avs_address, cip_pkg::OFS_PULL)) begin
                rd_reg[N-1:0] <= pen_reg;
                rd_reg[cip_pkg::PULL_SEL_POS +: N] <= pup_reg;
            end
        end
    end
    assign avs_readdata = rd_reg;

    ////////////////////////////////////////////////////////////////////
    // Pad cells, one per pin.

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pad
            cip_pad u_pad (
                .sw_dir  (dir_reg[g]),
                .sw_out  (out_reg[g]),
                .alt_sel (alt_reg[g]),
                .alt_dir (alt_dir[g]),
                .alt_out (alt_out[g]),
                .pad_o   (pad_o[g]),
                .pad_oe  (pad_oe[g])
            );
        end
    endgenerate

    // Pulls pass straight to the pad cells.
    assign pad_pull_en = pen_reg;
    assign pad_pull_up = pup_reg;

    // The sixth pin's driven level doubles as the receiver enable;
    // it is low whenever that pin does not drive.
    assign position_receiver_enable =
        pad_oe[cip_pkg::RX_EN_PIN] & pad_o[cip_pkg::RX_EN_PIN];

    ////////////////////////////////////////////////////////////////////
    // Checks.

    // A write to the output word commits at this edge.
    sequence s_out_write;
        wr_now && avs_address == {1'b0, cip_pkg::OFS_OUT}
            && avs_byteenable[0];
    endsequence

    // A write to the direction word commits at this edge.
    sequence s_dir_write;
        wr_now && avs_address == {1'b0, cip_pkg::OFS_DIR}
            && avs_byteenable[0];
    endsequence

    // A write of the pull enables commits at this edge.
    sequence s_pull_write;
        wr_now && avs_address == cip_pkg::OFS_PULL
            && avs_byteenable[0];
    endsequence

    // A read is taken on the first enabled cycle of its request.
    sequence s_read_taken;
        clk_en && avs_read && !ack_reg;
    endsequence

    // Leaving reset, no pin drives its pad.
    a_reset_inputs: assert property (
        @(posedge sys_clk) $rose(rst_n)
        |-> dir_reg == '0 && pad_oe == '0
    ) else $error("pin not input after reset");

    a_input_write_ignored: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_out_write |=> ((out_reg ^ $past(out_reg)) & ~$past(dir_reg)) == '0
    ) else $error("write to input pin changed value");

    a_output_write_lands: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_out_write |=> ((out_reg ^ $past(avs_writedata[N-1:0]))
                         & $past(dir_reg)) == '0
    ) else $error("output write lost");

    a_alt_overrides: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ((pad_oe ^ alt_dir) & alt_reg) == '0
    ) else $error("alternate function not in control");

    a_driver_released: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ((pad_oe ^ dir_reg) & ~alt_reg) == '0
    ) else $error("driver not following direction");

    a_push_pull: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ((pad_o ^ out_reg) & dir_reg & ~alt_reg) == '0
    ) else $error("output level not driven");

    a_read_pad: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && avs_read && !ack_reg
            && avs_address == {1'b0, cip_pkg::OFS_IN})
        |=> avs_readdata[N-1:0] == $past(pad_i)
    ) else $error("input read mismatch");

    a_receiver_enable: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        position_receiver_enable |-> pad_oe[cip_pkg::RX_EN_PIN]
    ) else $error("receiver enable without drive");

    // A taken read is answered at the next enabled edge.
    a_wait_bounded: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_taken ##1 clk_en |-> !avs_waitrequest
    ) else $error("access not answered");

    // A taken write commits at the next enabled edge.
    a_write_answered: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && avs_write && !ack_reg) ##1 clk_en |-> wr_now
    ) else $error("write not committed");

    // A direction write lands whole.
    a_dir_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_dir_write |=> dir_reg == $past(avs_writedata[N-1:0])
    ) else $error("direction write lost");

    // A pull enable write lands whole.
    a_pull_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_pull_write |=> pen_reg == $past(avs_writedata[N-1:0])
    ) else $error("pull write lost");

    // A selected pin carries the function's level, not software's.
    a_alt_level: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ((pad_o ^ alt_out) & alt_reg) == '0
    ) else $error("function level not on pad");

    // Reading the output word returns the value that is set.
    a_read_out: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_taken ##0 (avs_address == {1'b0, cip_pkg::OFS_OUT})
        |=> avs_readdata[N-1:0] == $past(out_reg)
    ) else $error("output read mismatch");

    // Read data stands until the next read is taken.
    a_read_stands: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(clk_en && avs_read && !ack_reg) |=> $stable(avs_readdata)
    ) else $error("read data moved");

    // A low clock enable freezes every register of the block.
    a_freeze_state: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !clk_en |=> $stable(dir_reg) && $stable(out_reg)
            && $stable(alt_reg) && $stable(pen_reg)
            && $stable(pup_reg) && $stable(ack_reg)
            && $stable(rd_reg)
    ) else $error("state moved while frozen");

endmodule : cip_port

/* cip_pkg.sv */
// Constants for the configurable six-pin port.
// Assumes a single 40 MHz clock and an Avalon-MM register slave.
package cip_pkg;

    // Number of pins on the port.
    localparam int unsigned PIN_COUNT = 6;

    // Index of the pin that may drive the receiver enable line.
    localparam int unsigned RX_EN_PIN = 5;

    // Register word byte offsets.
    localparam logic [3:0] OFS_DIR    = 4'h0;
    localparam logic [3:0] OFS_OUT    = 4'h4;
    localparam logic [3:0] OFS_IN     = 4'h8;
    localparam logic [3:0] OFS_ALT    = 4'hc;

    // Pull configuration word: enables in the low byte, up/down above.
    localparam logic [4:0] OFS_PULL   = 5'h10;
    localparam int unsigned PULL_SEL_POS = 8;

    // Reset values: every pin an input, outputs low, no alternate use.
    localparam logic [5:0] DIR_RST    = 6'h00;
    localparam logic [5:0] OUT_RST    = 6'h00;
    localparam logic [5:0] ALT_RST    = 6'h00;
    localparam logic [5:0] PULL_EN_RST  = 6'h00;
    localparam logic [5:0] PULL_SEL_RST = 6'h00;

    // Read data for an unmapped address.
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

endpackage : cip_pkg

/* cip_pad.sv */
// One pad cell's steering: chooses software or function control.
// Assumes the top level resolves the wire from the enable.
`timescale 1ns/1ps

module cip_pad (
    // Software control.
    input  wire logic sw_dir,
    input  wire logic sw_out,
    // Alternate function control.
    input  wire logic alt_sel,
    input  wire logic alt_dir,
    input  wire logic alt_out,
    // Pad drive.
    output logic      pad_o,
    output logic      pad_oe
);

    // The function logic owns the pad when selected, else software.
    always_comb begin
        if (alt_sel) begin
            pad_o  = alt_out;
            pad_oe = alt_dir;
        end else begin
            // Push-pull: the same value drives high and low.
            pad_o  = sw_out;
            pad_oe = sw_dir;
        end
    end

endmodule : cip_pad

/* cip_pad_model.sv */
// External digital devices on the six pads, with wire resolution.
// Assumes the bench sets each device's drive enable and level.
`timescale 1ns/1ps

module cip_pad_model (
    // Clock.
    input  wire logic       sys_clk,
    // Port side of the pads.
    input  wire logic [5:0] pad_o,
    input  wire logic [5:0] pad_oe,
    input  wire logic [5:0] pad_pull_en,
    input  wire logic [5:0] pad_pull_up,
    // External device drive.
    input  wire logic [5:0] ext_oe,
    input  wire logic [5:0] ext_val,
    // Resolved wire levels.
    output logic [5:0]      pad_i
);
    // A floating pin wanders every cycle, so no stale level can pass.
    logic [5:0] float_reg = 6'h15;
    always @(posedge sys_clk) begin
        float_reg <= ~float_reg;
    end
    // The port wins where it drives; an enabled pull sets a pin that nothing drives.
    // Nothing here judges pad levels while the port is in reset.
    assign pad_i = (pad_oe & pad_o)
                 | (~pad_oe & ext_oe & ext_val)
                 | (~pad_oe & ~ext_oe & pad_pull_en & pad_pull_up)
                 | (~pad_oe & ~ext_oe & ~pad_pull_en & float_reg);
endmodule : cip_pad_model

/* cip_port_tb_top.sv */
// Self-checking bench for the six-pin port and its register slave.
// Assumes the pad model resolves every wire.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    $display("Error %s expected %h seen %h", nm, e, g); \
    fail_count++; end end

module cip_port_tb_top;
    logic sys_clk = 0, rst_n = 0, clk_en = 1;
    logic [4:0]  avs_address = 0;
    logic avs_read = 0, avs_write = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q, w, v;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [5:0]  alt_dir = 0, alt_out = 0, ext_oe = 0, ext_val = 0;
    logic [5:0]  pad_i, pad_o, pad_oe, pull_en, pull_up, dir_m, out_m, oe;
    logic        avs_waitrequest, rx_en;
    int          fail_count = 0, checks = 0, seed = 32'hd040;
    logic [4:0]  regs [5] = '{5'h00, 5'h04, 5'h0c, 5'h10, 5'h14};

    always #12.5 sys_clk = ~sys_clk;

    cip_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .alt_dir(alt_dir),
        .alt_out(alt_out), .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe),
        .pad_pull_en(pull_en), .pad_pull_up(pull_up),
        .position_receiver_enable(rx_en));
    cip_pad_model pads (.sys_clk(sys_clk), .pad_o(pad_o), .pad_oe(pad_oe),
        .pad_pull_en(pull_en), .pad_pull_up(pull_up), .ext_oe(ext_oe),
        .ext_val(ext_val), .pad_i(pad_i));

    // Level on each wire while software owns every pin.
    function automatic logic [31:0] lvl(input logic [5:0] d, o, x);
        return {26'h0, (d & o) | (~d & x)};
    endfunction : lvl

    // One Avalon access; held until waitrequest is sampled low at a
    // rising edge, where read data is taken and the request dropped.
    // Only the watchdog ends a wait that never finishes.
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        dir_m = 0;
        out_m = 0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        `CHK("oe_rst", 6'h00, pad_oe)
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, regs[i], 32'h0, q);
            `CHK("reg_rst", 32'h0, q)
        end
        // Random directions, outputs and far-side levels.
        for (int k = 0; k < 40; k++) begin
            w = $random(seed);
            v = $random(seed);
            if (k == 0) w[5:0] = 6'h3f;
            dir_m = w[5:0];
            ext_oe <= ~w[5:0];
            ext_val <= w[13:8];
            bus(1'b1, 5'h00, w, q);
            `CHK("oe", dir_m, pad_oe)
            out_m = (out_m & ~dir_m) | (v[5:0] & dir_m);
            bus(1'b1, 5'h04, v, q);
            `CHK("drive", out_m & dir_m, pad_o & pad_oe)
            `CHK("rx_en", dir_m[5] & out_m[5], rx_en)
            bus(1'b0, 5'h04, 32'h0, q);
            `CHK("out_rd", {26'h0, out_m}, q)
            bus(1'b0, 5'h08, 32'h0, q);
            `CHK("in_rd", lvl(dir_m, out_m, w[13:8]), q)
            bus(1'b1, 5'h10, v, q);
            `CHK("pull", {v[13:8], v[5:0]}, {pull_up, pull_en})
        end
        // Function control overrides software on selected pins.
        for (int k = 0; k < 8; k++) begin
            w = $random(seed);
            alt_dir <= w[13:8];
            alt_out <= w[21:16];
            bus(1'b1, 5'h0c, w, q);
            oe = (w[5:0] & w[13:8]) | (~w[5:0] & dir_m);
            `CHK("alt_oe", oe, pad_oe)
            v = {26'h0, (w[5:0] & w[21:16]) | (~w[5:0] & out_m)};
            `CHK("alt_o", v[5:0] & oe, pad_o & pad_oe)
            `CHK("alt_rx", oe[5] & v[5], rx_en)
        end
        bus(1'b1, 5'h0c, 32'h0, q);
        bus(1'b1, 5'h00, 32'h0, q);
        `CHK("release", 6'h00, pad_oe)
        bus(1'b1, 5'h00, 32'h3f, q);
        `CHK("kept", out_m, pad_o)
        // A write waits out a frozen clock enable and then lands.
        oe = pad_oe;
        clk_en <= 1'b0;
        fork
            begin
                repeat (4) @(posedge sys_clk);
                `CHK("frozen", oe, pad_oe)
                clk_en <= 1'b1;
            end
            bus(1'b1, 5'h00, 32'h15, q);
        join
        `CHK("thawed", 6'h15, pad_oe)
        // A reset in mid-run returns every pin to an input.
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        `CHK("oe_rst2", 6'h00, pad_oe)
        bus(1'b0, 5'h04, 32'h0, q);
        `CHK("out_rst2", 32'h0, q)
        // Undriven pins settle to the pull level that software chose.
        ext_oe <= 6'h00;
        w = $random(seed);
        w[5:0] = 6'h3f;
        bus(1'b1, 5'h10, w, q);
        bus(1'b0, 5'h08, 32'h0, q);
        `CHK("pulled", {26'h0, w[13:8]}, q)
        test_done();
    end
endmodule : cip_port_tb_top
